/* File: design/ccss_pkg.sv */
// Purpose: Shared constants for the codec clock setup sequencer.
// Assumes: One system clock at CLK_HZ; registers are eight bits wide.
// Notes:   Lock times are maximum figures, so their cycle counts round down.
`default_nettype none
package ccss_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 40;

	// Register offsets.
	localparam logic [7:0] CCSS_OFS_CTRL   = 8'h00;
	localparam logic [7:0] CCSS_OFS_FORMAT = 8'h01;
	localparam logic [7:0] CCSS_OFS_RATE   = 8'h02;
	localparam logic [7:0] CCSS_OFS_STATUS = 8'h03;

	// Control register fields.
	localparam int CTRL_PLL_POWER_BIT      = 0;
	localparam int CTRL_CRYSTAL_POWER_BIT  = 1;
	localparam int CTRL_BIAS_POWER_BIT     = 2;
	localparam int CTRL_MASTER_MODE_BIT    = 3;
	localparam int CTRL_MCK_PULLDOWN_BIT   = 7;
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h8f;
	localparam logic [7:0] CTRL_RESET      = 8'h80;

	// Format register fields.
	localparam int FMT_IF_FORMAT_LSB       = 0;
	localparam int FMT_PLL_REF_LSB         = 2;
	localparam int FMT_MSB_ALIGN_BIT       = 5;
	localparam int FMT_BCK_POLARITY_BIT    = 6;
	localparam logic [7:0] FMT_WRITE_MASK  = 8'h7f;
	localparam logic [7:0] FMT_RESET       = 8'h00;

	// Rate register fields.
	localparam int RATE_SAMPLE_LSB         = 0;
	localparam int RATE_BCK_RATE_LSB       = 3;
	localparam int RATE_EXT_RATE_LSB       = 5;
	localparam logic [7:0] RATE_WRITE_MASK = 8'h7f;
	localparam logic [7:0] RATE_RESET      = 8'h00;

	// Status register fields.
	localparam int STAT_LOCK_PENDING_BIT   = 0;
	localparam int STAT_LOCKED_BIT         = 1;
	localparam int STAT_CLOCKS_READY_BIT   = 2;
	localparam int STAT_MCK_PRESENT_BIT    = 3;
	localparam int STAT_FCK_PRESENT_BIT    = 4;
	localparam int STAT_BCK_PRESENT_BIT    = 5;
	localparam int STAT_PLL_MODE_BIT       = 6;
	localparam int STAT_REF_INVALID_BIT    = 7;

	// Reference select codes.
	localparam logic [2:0] REF_FCK_1FS     = 3'h0;
	localparam logic [2:0] REF_BCK_64FS    = 3'h3;
	localparam logic [2:0] REF_MCK_LAST    = 3'h6;
	localparam logic [2:0] REF_NONE        = 3'h7;

	// Detector channel indices.
	localparam int DET_MCK                 = 0;
	localparam int DET_FCK                 = 1;
	localparam int DET_BCK                 = 2;
	localparam int DET_COUNT               = 3;

	// Timing: maximum lock times, rounded down to whole cycles.
	localparam int unsigned LOCK_MCK_MS    = 40;
	localparam int unsigned LOCK_FCK_MS    = 160;
	localparam int unsigned LOCK_BCK_MS    = 2;
	localparam int unsigned LOCK_MCK_CYC   = LOCK_MCK_MS * (CLK_HZ / 1000);
	localparam int unsigned LOCK_FCK_CYC   = LOCK_FCK_MS * (CLK_HZ / 1000);
	localparam int unsigned LOCK_BCK_CYC   = LOCK_BCK_MS * (CLK_HZ / 1000);
	localparam int          LOCK_CNT_W     = 23;

	// A pin counts as clocked if it toggles within this window.
	localparam int unsigned PRESENT_US     = 160;
	localparam int unsigned PRESENT_CYC    = (PRESENT_US * 1000) / CLK_PERIOD_NS;

	// Generated bit clock half period in system cycles.
	localparam int unsigned BCK_HALF_CYC   = 24;
endpackage
`default_nettype wire

/* File: design/ccss_detect_if.sv */
// Purpose: Carries one clock pin between the sequencer and its activity detector.
// Assumes: The pin is asynchronous to the system clock.
// Notes:   The detector owns synchronisation; the sequencer reads only present.
`default_nettype none
interface ccss_detect_if;
	logic pin;
	logic present;
	modport detector (input pin, output present);
	modport owner    (output pin, input present);
endinterface
`default_nettype wire

/* File: design/ccss_clk_detect.sv */
// Purpose: Tells whether a clock pin is toggling.
// Assumes: Pin passes two flip-flops before any logic looks at it.
// Notes:   Clocks near or above half the system rate alias, but still show edges.
`default_nettype none
module ccss_clk_detect
	import ccss_pkg::*;
#(
	parameter int unsigned TIMEOUT = PRESENT_CYC
) (
	input  wire logic    clk,
	input  wire logic    rst,
	ccss_detect_if.detector det
);
	localparam int W = $clog2(TIMEOUT + 1);

	logic         sync1;
	logic         sync2;
	logic         last;
	logic [W-1:0] idle;
	logic         present;
	logic [W-1:0] next_idle;
	logic         next_present;

	always_comb begin
		next_idle    = idle;
		next_present = present;
		if (sync2 != last) begin
			next_idle    = '0;
			next_present = 1'b1;
		end else if (idle == W'(TIMEOUT)) begin
			next_present = 1'b0;
		end else begin
			next_idle = idle + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1   <= 1'b0;
			sync2   <= 1'b0;
			last    <= 1'b0;
			idle    <= '0;
			present <= 1'b0;
		end else begin
			sync1   <= det.pin;
			sync2   <= sync1;
			last    <= sync2;
			idle    <= next_idle;
			present <= next_present;
		end
	end

	assign det.present = present;
endmodule
`default_nettype wire

/* File: design/codec_clock_setup_sequencer.sv */
// Purpose: Clock source selection and power-up sequencing of a codec clock tree.
// Assumes: Host keeps its own sequencing duties; the clock pins and POWERDOWN_RESET_PIN_N are asynchronous to CLK.
// Notes:   Lock is modelled by worst-case lock timers, not by a real phase detector.
//
// Strobed register access and the register addresses were decided locally.
`default_nettype none
module codec_clock_setup_sequencer
	import ccss_pkg::*;
#(
	parameter int unsigned LOCK_MCK_CYCLES = LOCK_MCK_CYC,
	parameter int unsigned LOCK_FCK_CYCLES = LOCK_FCK_CYC,
	parameter int unsigned LOCK_BCK_CYCLES = LOCK_BCK_CYC,
	parameter int unsigned BCK_HALF        = BCK_HALF_CYC
) (
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	input  wire logic       POWERDOWN_RESET_PIN_N,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       MASTER_CLOCK_INPUT,
	input  wire logic       FRAME_CLOCK_PIN_I,
	output logic            FRAME_CLOCK_PIN_O,
	output logic            FRAME_CLOCK_PIN_OE,
	input  wire logic       BIT_CLOCK_PIN_I,
	output logic            BIT_CLOCK_PIN_O,
	output logic            BIT_CLOCK_PIN_OE,
	output logic            MASTER_CLOCK_PULLDOWN,
	output logic            CRYSTAL_ENABLE,
	output logic            BIAS_ENABLE,
	output logic            LOCK_PENDING,
	output logic            CLOCKS_READY
);
	typedef enum logic [1:0] {
		CCSS_OFF,
		CCSS_WAIT_REF,
		CCSS_LOCKING,
		CCSS_LOCKED
	} ccss_state_t;

	// Power-down pin synchroniser; the first stage feeds only the second.
	logic pdn_sync1;
	logic pdn_sync2;
	logic reg_rst;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pdn_sync1 <= 1'b0;
			pdn_sync2 <= 1'b0;
		end else begin
			pdn_sync1 <= POWERDOWN_RESET_PIN_N;
			pdn_sync2 <= pdn_sync1;
		end
	end

	// Everything but the synchronisers and detectors clears while the pin is low.
	assign reg_rst = SYS_RST | ~pdn_sync2;

	// Clock activity detectors, one per incoming clock pin.
	ccss_detect_if det [DET_COUNT] ();
	logic [DET_COUNT-1:0] present;

	assign det[DET_MCK].pin = MASTER_CLOCK_INPUT;
	assign det[DET_FCK].pin = FRAME_CLOCK_PIN_I;
	assign det[DET_BCK].pin = BIT_CLOCK_PIN_I;

	for (genvar g = 0; g < DET_COUNT; g++) begin : g_det
		ccss_clk_detect u_det (
			.clk (CLK),
			.rst (SYS_RST),
			.det (det[g])
		);
		assign present[g] = det[g].present;
	end

	// Register file.
	logic [7:0] ctrl;
	logic [7:0] fmt;
	logic [7:0] rate;
	logic [7:0] rdata;
	logic [7:0] status;
	logic [7:0] next_ctrl;
	logic [7:0] next_fmt;
	logic [7:0] next_rate;
	logic [7:0] next_rdata;

	logic       pll_power_bit;
	logic       crystal_power_bit;
	logic       bias_power_bit;
	logic       master_mode_bit;
	logic       master_clock_pulldown_bit;
	logic [2:0] pll_reference_select;
	logic [1:0] bitclock_rate_select;
	logic       bitclock_polarity_bit;

	assign pll_power_bit             = ctrl[CTRL_PLL_POWER_BIT];
	assign crystal_power_bit         = ctrl[CTRL_CRYSTAL_POWER_BIT];
	assign bias_power_bit            = ctrl[CTRL_BIAS_POWER_BIT];
	assign master_mode_bit           = ctrl[CTRL_MASTER_MODE_BIT];
	assign master_clock_pulldown_bit = ctrl[CTRL_MCK_PULLDOWN_BIT];
	assign pll_reference_select      = fmt[FMT_PLL_REF_LSB +: 3];
	assign bitclock_rate_select      = rate[RATE_BCK_RATE_LSB +: 2];
	assign bitclock_polarity_bit     = fmt[FMT_BCK_POLARITY_BIT];

	always_comb begin
		next_ctrl  = ctrl;
		next_fmt   = fmt;
		next_rate  = rate;
		next_rdata = 8'h00;
		if (WR) begin
			case (ADDR)
				CCSS_OFS_CTRL:   next_ctrl = WDATA & CTRL_WRITE_MASK;
				CCSS_OFS_FORMAT: next_fmt  = WDATA & FMT_WRITE_MASK;
				CCSS_OFS_RATE:   next_rate = WDATA & RATE_WRITE_MASK;
				default:         next_ctrl = ctrl;
			endcase
		end
		if (RD) begin
			case (ADDR)
				CCSS_OFS_CTRL:   next_rdata = ctrl;
				CCSS_OFS_FORMAT: next_rdata = fmt;
				CCSS_OFS_RATE:   next_rdata = rate;
				CCSS_OFS_STATUS: next_rdata = status;
				default:         next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (reg_rst) begin
			ctrl  <= CTRL_RESET;
			fmt   <= FMT_RESET;
			rate  <= RATE_RESET;
			rdata <= 8'h00;
		end else begin
			ctrl  <= next_ctrl;
			fmt   <= next_fmt;
			rate  <= next_rate;
			rdata <= next_rdata;
		end
	end

	assign RDATA = rdata;

	// Reference decode.
	logic ref_invalid;
	logic ref_present;
	logic [LOCK_CNT_W-1:0] lock_limit;

	always_comb begin
		ref_invalid = 1'b0;
		ref_present = 1'b0;
		lock_limit  = LOCK_CNT_W'(LOCK_MCK_CYCLES);
		if (pll_reference_select == REF_FCK_1FS) begin
			ref_present = present[DET_FCK];
			lock_limit  = LOCK_CNT_W'(LOCK_FCK_CYCLES);
		end else if (pll_reference_select <= REF_BCK_64FS) begin
			ref_present = present[DET_BCK];
			lock_limit  = LOCK_CNT_W'(LOCK_BCK_CYCLES);
		end else if (pll_reference_select <= REF_MCK_LAST) begin
			ref_present = present[DET_MCK];
			lock_limit  = LOCK_CNT_W'(LOCK_MCK_CYCLES);
		end else begin
			ref_invalid = 1'b1;
		end
	end

	// PLL sequencer. The bias must be up before the PLL is allowed to run,
	// which costs nothing and keeps a careless host from a half-biased start.
	ccss_state_t           state;
	ccss_state_t           next_state;
	logic [LOCK_CNT_W-1:0] lock_cnt;
	logic [LOCK_CNT_W-1:0] next_lock_cnt;
	logic                  pll_enable;

	assign pll_enable = pll_power_bit & bias_power_bit & ~ref_invalid;

	always_comb begin
		next_state    = state;
		next_lock_cnt = lock_cnt;
		case (state)
			CCSS_OFF: begin
				next_lock_cnt = '0;
				if (pll_enable) begin
					next_state = CCSS_WAIT_REF;
				end
			end
			CCSS_WAIT_REF: begin
				next_lock_cnt = '0;
				if (!pll_enable) begin
					next_state = CCSS_OFF;
				end else if (ref_present) begin
					next_state = CCSS_LOCKING;
				end
			end
			CCSS_LOCKING: begin
				if (!pll_enable) begin
					next_state = CCSS_OFF;
				end else if (lock_cnt >= lock_limit - LOCK_CNT_W'(1)) begin
					next_state = CCSS_LOCKED;
				end else begin
					next_lock_cnt = lock_cnt + LOCK_CNT_W'(1);
				end
			end
			CCSS_LOCKED: begin
				if (!pll_enable) begin
					next_state = CCSS_OFF;
				end else if (!ref_present) begin
					// A lost reference forces a fresh worst-case lock wait.
					next_state = CCSS_WAIT_REF;
				end
			end
			default: next_state = CCSS_OFF;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (reg_rst) begin
			state    <= CCSS_OFF;
			lock_cnt <= '0;
		end else begin
			state    <= next_state;
			lock_cnt <= next_lock_cnt;
		end
	end

	logic locked;
	logic ext_ready;
	logic ready;

	assign locked    = (state == CCSS_LOCKED);
	assign ext_ready = ~pll_power_bit & (&present);
	assign ready     = pll_power_bit ? locked : ext_ready;

	// Master clock generator: bit clock from a divider, frame clock every
	// 16, 32 or 64 bit clocks. Held idle until lock so the far end never
	// sees a runt or irregular edge.
	localparam int HW = $clog2(BCK_HALF + 1);

	logic [HW-1:0] half_cnt;
	logic          bck_gen;
	logic [5:0]    bit_cnt;
	logic          fck_gen;
	logic [HW-1:0] next_half_cnt;
	logic          next_bck_gen;
	logic [5:0]    next_bit_cnt;
	logic          next_fck_gen;
	logic [5:0]    bits_last;
	logic          gen_run;

	assign gen_run = master_mode_bit & locked;

	always_comb begin
		case (bitclock_rate_select)
			2'h0:    bits_last = 6'h0f;
			2'h1:    bits_last = 6'h1f;
			default: bits_last = 6'h3f;
		endcase
		next_half_cnt = half_cnt;
		next_bck_gen  = bck_gen;
		next_bit_cnt  = bit_cnt;
		next_fck_gen  = fck_gen;
		if (!gen_run) begin
			next_half_cnt = '0;
			next_bck_gen  = 1'b0;
			next_bit_cnt  = 6'h00;
			next_fck_gen  = 1'b0;
		end else if (half_cnt == HW'(BCK_HALF - 1)) begin
			next_half_cnt = '0;
			next_bck_gen  = ~bck_gen;
			if (bck_gen) begin
				next_bit_cnt = (bit_cnt >= bits_last) ? 6'h00 : bit_cnt + 6'h01;
				next_fck_gen = (bit_cnt >= bits_last);
			end
		end else begin
			next_half_cnt = half_cnt + HW'(1);
		end
	end

	always_ff @(posedge CLK) begin
		if (reg_rst) begin
			half_cnt <= '0;
			bck_gen  <= 1'b0;
			bit_cnt  <= 6'h00;
			fck_gen  <= 1'b0;
		end else begin
			half_cnt <= next_half_cnt;
			bck_gen  <= next_bck_gen;
			bit_cnt  <= next_bit_cnt;
			fck_gen  <= next_fck_gen;
		end
	end

	// Status and outputs.
	always_comb begin
		status = 8'h00;
		status[STAT_LOCK_PENDING_BIT] = (state == CCSS_LOCKING);
		status[STAT_LOCKED_BIT]       = locked;
		status[STAT_CLOCKS_READY_BIT] = ready;
		status[STAT_MCK_PRESENT_BIT]  = present[DET_MCK];
		status[STAT_FCK_PRESENT_BIT]  = present[DET_FCK];
		status[STAT_BCK_PRESENT_BIT]  = present[DET_BCK];
		status[STAT_PLL_MODE_BIT]     = pll_power_bit;
		status[STAT_REF_INVALID_BIT]  = ref_invalid;
	end

	assign LOCK_PENDING          = (state == CCSS_LOCKING);
	assign CLOCKS_READY          = ready;
	assign FRAME_CLOCK_PIN_O     = fck_gen;
	assign BIT_CLOCK_PIN_O       = bck_gen ^ bitclock_polarity_bit;
	assign FRAME_CLOCK_PIN_OE    = gen_run;
	assign BIT_CLOCK_PIN_OE      = gen_run;
	assign MASTER_CLOCK_PULLDOWN = master_clock_pulldown_bit;
	assign CRYSTAL_ENABLE        = crystal_power_bit;
	assign BIAS_ENABLE           = bias_power_bit;
endmodule
`default_nettype wire

/* File: tb/ccss_properties.sv */
// Purpose: Concurrent checks on the sequencer's top ports.
// Assumes: One clock domain; SYS_RST disables every check.
// Notes:   Lock and bit clock lengths are counted in helper registers.
`default_nettype none
module ccss_properties
	import ccss_pkg::*;
#(
	parameter int unsigned LOCK_MCK_CYCLES = LOCK_MCK_CYC,
	parameter int unsigned LOCK_FCK_CYCLES = LOCK_FCK_CYC,
	parameter int unsigned LOCK_BCK_CYCLES = LOCK_BCK_CYC,
	parameter int unsigned BCK_HALF        = BCK_HALF_CYC
) (
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       POWERDOWN_RESET_PIN_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       MASTER_CLOCK_INPUT,
	input wire logic       FRAME_CLOCK_PIN_I,
	input wire logic       FRAME_CLOCK_PIN_O,
	input wire logic       FRAME_CLOCK_PIN_OE,
	input wire logic       BIT_CLOCK_PIN_I,
	input wire logic       BIT_CLOCK_PIN_O,
	input wire logic       BIT_CLOCK_PIN_OE,
	input wire logic       MASTER_CLOCK_PULLDOWN,
	input wire logic       CRYSTAL_ENABLE,
	input wire logic       BIAS_ENABLE,
	input wire logic       LOCK_PENDING,
	input wire logic       CLOCKS_READY
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned pend_cnt;
	int unsigned high_cnt;

	// Both counters hold the length of the run that ends when their signal falls.
	always_ff @(posedge CLK) begin
		pend_cnt <= (SYS_RST || !LOCK_PENDING) ? 0 : pend_cnt + 1;
		high_cnt <= (SYS_RST || !BIT_CLOCK_PIN_O || !BIT_CLOCK_PIN_OE) ? 0 : high_cnt + 1;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence lock_done;
		$fell(LOCK_PENDING) && CLOCKS_READY;
	endsequence
	sequence pin_held_low;
		!POWERDOWN_RESET_PIN_N [*5];
	endsequence

	a_pending_blocks_ready: assert property (LOCK_PENDING |-> !CLOCKS_READY)
		else $error("clocks ready while lock is pending");
	a_lock_time_exact: assert property (lock_done |-> (pend_cnt == LOCK_MCK_CYCLES ||
		pend_cnt == LOCK_FCK_CYCLES || pend_cnt == LOCK_BCK_CYCLES))
		else $error("lock wait differs from every lock limit");
	a_oe_pair_match: assert property (FRAME_CLOCK_PIN_OE == BIT_CLOCK_PIN_OE)
		else $error("frame and bit clock enables differ");
	a_oe_after_lock: assert property (FRAME_CLOCK_PIN_OE |-> CLOCKS_READY && !LOCK_PENDING)
		else $error("clock outputs driven before lock");
	a_bck_half_period: assert property ($fell(BIT_CLOCK_PIN_O) && $past(BIT_CLOCK_PIN_OE) &&
		BIT_CLOCK_PIN_OE |-> high_cnt == BCK_HALF)
		else $error("bit clock high phase has wrong length");
	a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside the read slot");
	a_pin_defaults: assert property (pin_held_low |-> MASTER_CLOCK_PULLDOWN && !CRYSTAL_ENABLE
		&& !BIAS_ENABLE && !LOCK_PENDING && !FRAME_CLOCK_PIN_OE)
		else $error("outputs not at defaults under the reset pin");
	a_bias_for_pll: assert property (LOCK_PENDING |-> BIAS_ENABLE)
		else $error("lock started without bias power");
endmodule
`default_nettype wire

/* File: tb/ccss_clock_source.sv */
// Purpose: Host side clock source for the sequencer's clock pins.
// Assumes: Bit clock period 320 ns; a frame is sixteen bit clocks.
// Notes:   A stopped master clock floats unless the pulldown holds it.
`default_nettype none
module ccss_clock_source (
	input  wire logic mck_on,
	input  wire logic fck_on,
	input  wire logic bck_on,
	input  wire logic mck_pd,
	input  wire logic fck_oe,
	input  wire logic fck_o,
	input  wire logic bck_oe,
	input  wire logic bck_o,
	output logic      mck,
	output logic      frame_clock_pin,
	output logic      bck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic mck_src  = 1'b0;
	logic bck_src  = 1'b0;
	logic fck_src  = 1'b0;
	logic mck_last = 1'b0;
	int   div      = 0;

	initial begin
		#7;
		forever #40 mck_src = ~mck_src;
	end
	// Audio clocks run free while enabled, so frame follows bit clock.
	initial begin
		#13;
		forever begin
			#160 bck_src = ~bck_src;
			if (bck_src == 1'b0) begin
				div = (div + 1) % 8;
				if (div == 0)
					fck_src = ~fck_src;
			end
		end
	end
	// An undriven master clock line keeps no trustworthy level.
	always @(negedge mck_on) mck_last = ~mck_src;
	assign mck = mck_on ? mck_src : (mck_pd ? 1'b0 : mck_last);
	// The host never drives against the device and ignores its outputs.
	assign frame_clock_pin = fck_oe ? fck_o : (fck_on & fck_src);
	assign bck = bck_oe ? bck_o : (bck_on & bck_src);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the codec clock setup sequencer.
// Assumes: Lock limits shortened to 200, 400 and 50 cycles.
// Notes:   The host clock source stands in for the far side.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ccss_pkg::*;
	localparam int LM = 200;
	localparam int LF = 400;
	localparam int LB = 50;
	localparam int BH = 4;
	logic       CLK = 0, SYS_RST = 1, POWERDOWN_RESET_PIN_N = 0, WR = 0, RD = 0;
	logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
	logic       MASTER_CLOCK_INPUT, FRAME_CLOCK_PIN_I, FRAME_CLOCK_PIN_O, FRAME_CLOCK_PIN_OE;
	logic       BIT_CLOCK_PIN_I, BIT_CLOCK_PIN_O, BIT_CLOCK_PIN_OE, MASTER_CLOCK_PULLDOWN;
	logic       CRYSTAL_ENABLE, BIAS_ENABLE, LOCK_PENDING, CLOCKS_READY;
	logic       mck_on = 0, fck_on = 0, bck_on = 0;
	int         miscompares = 0, check_count = 0, cycles = 0;

	codec_clock_setup_sequencer #(.LOCK_MCK_CYCLES(LM), .LOCK_FCK_CYCLES(LF),
		.LOCK_BCK_CYCLES(LB), .BCK_HALF(BH)) dut (.*);
	ccss_clock_source src (.mck_on(mck_on), .fck_on(fck_on), .bck_on(bck_on),
		.mck_pd(MASTER_CLOCK_PULLDOWN), .fck_oe(FRAME_CLOCK_PIN_OE),
		.fck_o(FRAME_CLOCK_PIN_O), .bck_oe(BIT_CLOCK_PIN_OE), .bck_o(BIT_CLOCK_PIN_O),
		.mck(MASTER_CLOCK_INPUT), .frame_clock_pin(FRAME_CLOCK_PIN_I), .bck(BIT_CLOCK_PIN_I));

	initial begin
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares = miscompares + 1;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(what, RDATA, exp);
	endtask
	// Flags are sampled just after the edge so that its updates have landed.
	task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge CLK);
			#1 n++;
		end
	endtask

	task automatic t_reset();
		rd_chk(CCSS_OFS_CTRL, CTRL_RESET, "ctrl");
		rd_chk(CCSS_OFS_FORMAT, FMT_RESET, "format");
		rd_chk(CCSS_OFS_RATE, RATE_RESET, "rate");
		rd_chk(8'h04, 8'h00, "unmapped");
		chk("pulldown", MASTER_CLOCK_PULLDOWN, 1'b1);
		wr(CCSS_OFS_CTRL, 8'hf0);
		rd_chk(CCSS_OFS_CTRL, 8'hf0 & CTRL_WRITE_MASK, "ctrl mask");
		wr(CCSS_OFS_FORMAT, 8'hff);
		rd_chk(CCSS_OFS_FORMAT, FMT_WRITE_MASK, "format mask");
		wr(CCSS_OFS_STATUS, 8'hff);
		// The format write above leaves select 7, so only the invalid flag stands.
		rd_chk(CCSS_OFS_STATUS, 8'(1 << STAT_REF_INVALID_BIT), "status read only");
	endtask
	task automatic t_ext();
		int n;
		wr(CCSS_OFS_CTRL, 8'h04);
		mck_on <= 1'b1;
		fck_on <= 1'b1;
		repeat (300) @(posedge CLK);
		chk("ready two clocks", CLOCKS_READY, 1'b0);
		bck_on <= 1'b1;
		wait_lvl(CLOCKS_READY, 1'b1, 50, n);
		chk("ready three clocks", CLOCKS_READY, 1'b1);
		rd_chk(CCSS_OFS_STATUS, 8'hbc, "ext status");
		@(posedge CLK);
		bck_on <= 1'b0;
		wait_lvl(CLOCKS_READY, 1'b0, PRESENT_CYC + 20, n);
		chk("ready lost", CLOCKS_READY, 1'b0);
		@(posedge CLK);
		bck_on <= 1'b1;
	endtask
	task automatic t_lock();
		int n;
		int lim;
		for (int s = 0; s < 8; s++) begin
			lim = (s == 0) ? LF : (s < 4) ? LB : LM;
			wr(CCSS_OFS_CTRL, 8'h04);
			wr(CCSS_OFS_FORMAT, 8'(s << FMT_PLL_REF_LSB));
			wr(CCSS_OFS_CTRL, (s < 4) ? 8'h85 : 8'h05);
			wait_lvl(LOCK_PENDING, 1'b1, 20, n);
			wait_lvl(LOCK_PENDING, 1'b0, lim + 20, n);
			chk("lock cycles", n, (s == 7) ? 0 : lim);
			chk("ready after lock", CLOCKS_READY, s != 7);
			rd_chk(CCSS_OFS_STATUS, (s == 7) ? 8'hf8 : 8'h7e, "pll status");
		end
	endtask
	task automatic t_ref_wait();
		int n;
		wr(CCSS_OFS_CTRL, 8'h04);
		wr(CCSS_OFS_FORMAT, 8'h10);
		mck_on <= 1'b0;
		repeat (PRESENT_CYC + 20) @(posedge CLK);
		wr(CCSS_OFS_CTRL, 8'h05);
		wait_lvl(LOCK_PENDING, 1'b1, 300, n);
		chk("pending without mck", LOCK_PENDING, 1'b0);
		@(posedge CLK);
		mck_on <= 1'b1;
		wait_lvl(LOCK_PENDING, 1'b1, 20, n);
		chk("pending with mck", LOCK_PENDING, 1'b1);
		wait_lvl(LOCK_PENDING, 1'b0, LM + 20, n);
		chk("mck lock cycles", n, LM);
	endtask
	task automatic t_master();
		int n;
		wr(CCSS_OFS_CTRL, 8'h04);
		wr(CCSS_OFS_RATE, 8'h00);
		fck_on <= 1'b0;
		bck_on <= 1'b0;
		wr(CCSS_OFS_CTRL, 8'h0f);
		wait_lvl(LOCK_PENDING, 1'b1, 20, n);
		chk("oe during lock", FRAME_CLOCK_PIN_OE, 1'b0);
		wait_lvl(LOCK_PENDING, 1'b0, LM + 20, n);
		chk("oe after lock", {FRAME_CLOCK_PIN_OE, BIT_CLOCK_PIN_OE}, 2'b11);
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b1, 200, n);
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b0, 200, n);
		chk("frame high", n, 2 * BH);
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b1, 200, n);
		chk("frame low", n, 15 * 2 * BH);
		wr(CCSS_OFS_RATE, 8'(1 << RATE_BCK_RATE_LSB));
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b1, 300, n);
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b0, 300, n);
		wait_lvl(FRAME_CLOCK_PIN_O, 1'b1, 300, n);
		chk("frame low 32", n, 31 * 2 * BH);
	endtask
	task automatic t_pin_reset();
		@(posedge CLK);
		POWERDOWN_RESET_PIN_N <= 1'b0;
		repeat (5) @(posedge CLK);
		#1 chk("pin reset", {MASTER_CLOCK_PULLDOWN, CRYSTAL_ENABLE, BIAS_ENABLE}, 3'b100);
		@(posedge CLK);
		POWERDOWN_RESET_PIN_N <= 1'b1;
		repeat (3) @(posedge CLK);
		rd_chk(CCSS_OFS_CTRL, CTRL_RESET, "ctrl after pin");
		rd_chk(CCSS_OFS_FORMAT, FMT_RESET, "format after pin");
	endtask

	initial begin
		repeat (20) @(posedge CLK);
		SYS_RST <= 1'b0;
		POWERDOWN_RESET_PIN_N <= 1'b1;
		repeat (3) @(posedge CLK);
		t_reset();
		t_ext();
		t_lock();
		t_ref_wait();
		t_master();
		t_pin_reset();
		conclude();
	end
endmodule

bind codec_clock_setup_sequencer ccss_properties #(.LOCK_MCK_CYCLES(LOCK_MCK_CYCLES),
	.LOCK_FCK_CYCLES(LOCK_FCK_CYCLES), .LOCK_BCK_CYCLES(LOCK_BCK_CYCLES),
	.BCK_HALF(BCK_HALF)) u_props (.*);
`default_nettype wire
